// ==== bench/cpu_wait_interrupt_reset_control_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module cpu_wait_interrupt_reset_control_test;
  logic clk_sys = 1'b0, rstn = 1'b0, cpu_reset_n = 1'b0, nmi_n = 1'b1, irq_n = 1'b1;
  logic core_write = 1'b0, core_instr_done = 1'b0, mask_clear = 1'b0, slow = 1'b0, hold = 1'b0;
  logic ready_in, core_advance, rw_read, bus_avail, mask_flag, vector_load, int_busy;
  logic [15:0] addr;
  logic [7:0] mem_rdata, pc_low_byte, pc_high_byte, wdata;
  logic [7:0] wd [0:2];
  logic [15:0] wa [0:2];
  int miscompares = 0, cmp_count = 0, cycles = 0, n, nw;
  cwi_ctrl cwi_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .cpu_reset_n(cpu_reset_n),
    .ready_in(ready_in), .nmi_n(nmi_n), .irq_n(irq_n), .core_write(core_write),
    .core_instr_done(core_instr_done), .mask_clear(mask_clear), .mask_set(1'b0),
    .core_pc_low_byte(8'h34), .core_pc_high_byte(8'h12), .core_status(8'h5a),
    .mem_rdata(mem_rdata), .core_advance(core_advance), .rw_read(rw_read), .bus_avail(bus_avail),
    .addr(addr), .wdata(wdata), .mask_flag(mask_flag), .pc_low_byte(pc_low_byte),
    .pc_high_byte(pc_high_byte), .vector_load(vector_load), .int_busy(int_busy));
  cwi_mem_model cwi_mem_model_i (.clk_sys(clk_sys), .slow(slow), .hold(hold), .rw_read(rw_read),
    .addr(addr), .ready_in(ready_in), .mem_rdata(mem_rdata));
  // Free-running system clock.
  initial forever #5 clk_sys = ~clk_sys;
  // A hang is cut short long after the whole sequence should have ended.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Waits, bounded, for the vector pulse; counts cycles in n and writes in nw.
  task automatic wait_vl();
    n = 0;
    nw = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (rw_read === 1'b0) begin
        if (nw < 3) begin
          wd[nw] = wdata;
          wa[nw] = addr;
        end
        nw++;
      end
    end while (vector_load !== 1'b1 && n < 100);
    `CHK(vector_load, 1'b1)
  endtask
  // The three stacked bytes: counter high, counter low, status, walking down from the top.
  task automatic check_push(input logic [15:0] top);
    `CHK(wa[0], top)
    `CHK(wa[2], top - 16'h0002)
    `CHK(wd[0], 8'h12)
    `CHK(wd[1], 8'h34)
    `CHK(wd[2], 8'h5a)
  endtask
  task automatic pulse_clear();
    @(posedge clk_sys) mask_clear <= 1'b1;
    @(posedge clk_sys) mask_clear <= 1'b0;
  endtask
  // Reset held with a write pending, then the start-up vector read from slow memory.
  task automatic reset_seq();
    @(posedge clk_sys) core_write <= 1'b1;
    slow <= 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK(rw_read, 1'b1)
    @(posedge clk_sys) cpu_reset_n <= 1'b1;
    core_write <= 1'b0;
    wait_vl();
    // Two edges to raise and see the pin, six of delay, then two reads of three cycles each from slow memory.
    `CHK(n, 2 + 6 + 3 + 3)
    // The memory answers each read with its low address byte.
    `CHK({pc_high_byte, pc_low_byte}, 16'hfdfc)
    `CHK(nw, 0)
    `CHK(mask_flag, 1'b1)
    @(posedge clk_sys) slow <= 1'b0;
  endtask
  // The level request waits while masked, then is stacked and vectored.
  task automatic irq_test();
    @(posedge clk_sys) irq_n <= 1'b0;
    core_instr_done <= 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK(int_busy, 1'b0)
    `CHK(mask_flag, 1'b1)
    pulse_clear();
    wait_vl();
    `CHK({pc_high_byte, pc_low_byte}, 16'hfffe)
    `CHK(nw, 3)
    check_push(16'h01ff);
    `CHK(mask_flag, 1'b1)
    @(posedge clk_sys) irq_n <= 1'b1;
  endtask
  // The edge request breaks into the level handler with the mask cleared, then again with it set.
  task automatic nmi_test();
    pulse_clear();
    @(negedge clk_sys);
    `CHK(mask_flag, 1'b0)
    @(posedge clk_sys) nmi_n <= 1'b0;
    wait_vl();
    `CHK({pc_high_byte, pc_low_byte}, 16'hfbfa)
    check_push(16'h01fc);
    `CHK(mask_flag, 1'b1)
    repeat (20) @(negedge clk_sys);
    `CHK(int_busy, 1'b0)
    @(posedge clk_sys) nmi_n <= 1'b1;
    @(posedge clk_sys) nmi_n <= 1'b0;
    @(posedge clk_sys) nmi_n <= 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK(int_busy, 1'b0)
    `CHK(mask_flag, 1'b1)
    @(posedge clk_sys) nmi_n <= 1'b0;
    wait_vl();
    `CHK({pc_high_byte, pc_low_byte}, 16'hfbfa)
    check_push(16'h01f9);
    @(posedge clk_sys) nmi_n <= 1'b1;
  endtask
  // Ready held low: writes go on, the next read stalls and the bus is offered.
  task automatic ready_test();
    @(posedge clk_sys) hold <= 1'b1;
    core_write <= 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(core_advance, 1'b1)
    `CHK(bus_avail, 1'b0)
    @(posedge clk_sys) core_write <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (bus_avail !== 1'b1 && n < 8);
    `CHK(n < 5, 1'b1)
    `CHK(core_advance, 1'b0)
    @(posedge clk_sys) hold <= 1'b0;
    @(negedge clk_sys);
    `CHK(core_advance, 1'b1)
    repeat (2) @(negedge clk_sys);
    `CHK(bus_avail, 1'b0)
  endtask
  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reset_seq();
    irq_test();
    nmi_test();
    ready_test();
    print_verdict();
  end
endmodule // cpu_wait_interrupt_reset_control_test
`default_nettype wire

// ==== bench/cwi_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Slow memory that answers reads with the low address byte.
module cwi_mem_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic hold,
  input wire logic rw_read,
  input wire logic [15:0] addr,
  output logic ready_in,
  output logic [7:0] mem_rdata
);
  logic [15:0] last_reg = 16'h0000;
  logic [1:0] wait_reg = 2'h0;
  // Each new read address costs two wait cycles when slow, like a slow PROM.
  always @(posedge clk_sys) begin
    last_reg <= addr;
    if (slow && rw_read && addr != last_reg) begin
      wait_reg <= 2'h1;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end
  end
  // Ready drops as soon as a fresh address shows, just after the edge, which stands for the first phase.
  assign ready_in = !hold && !(slow && rw_read && (addr != last_reg || wait_reg != 2'h0));
  // The memory does not drive during writes, so the lines show a changing pattern.
  assign mem_rdata = rw_read ? addr[7:0] : ~addr[7:0];
endmodule // cwi_mem_model
`default_nettype wire

// ==== rtl/cwi_consts.svh ====
`ifndef CWI_CONSTS_SVH
`define CWI_CONSTS_SVH
// Vector addresses, reset delay and minimum low time of the edge request.
`define CWI_RESET_VEC_LO 16'hFFFC
`define CWI_RESET_VEC_HI 16'hFFFD
`define CWI_NMI_VEC_LO 16'hFFFA
`define CWI_NMI_VEC_HI 16'hFFFB
`define CWI_IRQ_VEC_LO 16'hFFFE
`define CWI_IRQ_VEC_HI 16'hFFFF
`define CWI_RESET_DELAY 4'h6
`define CWI_NMI_MIN_LOW 2'h2
`define CWI_BA_MAX_HALF 4'h7
`endif

// ==== rtl/cwi_ctrl.sv ====
// What this block does
// - Low ready input holds the current cycle.
// - Ready sampled and applied in the same cycle.
// - Write cycles ignore ready; stop at next read.
// - Edge request always taken after instruction.
// - Edge request fires only on falling transition.
// - Edge request held low two cycles minimum.
// - Level request taken when low and unmasked.
// - Masked level request stays pending until unmasked.
// - Accept stacks counter, status; mask set at vector.
// - Edge request also sets the mask flag.
// - Edge request preempts level handler, then resumes.
// - Writes suppressed while reset input low.
// - After reset wait 6, vector FFFC/FFFD.
// - Direction high except in write cycles.
// - Bus-available rises one cycle after first stalled read cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cwi_consts.svh"
module cwi_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cpu_reset_n,
  input wire logic ready_in,
  input wire logic nmi_n,
  input wire logic irq_n,
  input wire logic core_write,
  input wire logic core_instr_done,
  input wire logic mask_clear,
  input wire logic mask_set,
  input wire logic [7:0] core_pc_low_byte,
  input wire logic [7:0] core_pc_high_byte,
  input wire logic [7:0] core_status,
  input wire logic [7:0] mem_rdata,
  output logic core_advance,
  output logic rw_read,
  output logic bus_avail,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic mask_flag,
  output logic [7:0] pc_low_byte,
  output logic [7:0] pc_high_byte,
  output logic vector_load,
  output logic int_busy
);
  cwi_pkg::cwi_state_type state_reg;
  cwi_pkg::cwi_state_type state_next;
  cwi_pkg::cwi_src_type src_reg;
  cwi_pkg::cwi_src_type src_next;
  logic [3:0] delay_reg;
  logic [3:0] delay_next;
  logic [1:0] push_idx_reg;
  logic [1:0] push_idx_next;
  logic mask_reg;
  logic mask_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic write_reg;
  logic write_next;
  logic [7:0] stack_reg;
  logic [7:0] stack_next;
  logic [7:0] pcl_reg;
  logic [7:0] pcl_next;
  logic [7:0] pch_reg;
  logic [7:0] pch_next;
  logic vec_load_reg;
  logic vec_load_next;
  logic ba_reg;
  logic ba_next;
  logic nmi_pending;
  logic nmi_take;
  logic irq_take;
  logic stall;

  // The edge request is caught and held by its own detector.
  cwi_edge_detect #(
    .MIN_LOW(`CWI_NMI_MIN_LOW)
  ) u_nmi (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .req_n(nmi_n),
    .clear(nmi_take),
    .pending(nmi_pending)
  );

  // Ready is sampled at the edge that closes the cycle, so slow memory can stretch the read it serves.
  // Only a write of the running core is exempt; the sequencer's own vector cycles are reads.
  assign stall = !ready_in && !(core_write && state_reg == cwi_pkg::CWI_RUN);
  assign nmi_take = (state_reg == cwi_pkg::CWI_RUN) && core_instr_done && !stall && nmi_pending;
  assign irq_take = (state_reg == cwi_pkg::CWI_RUN) && core_instr_done && !stall && !nmi_pending
    && !irq_n && !mask_reg;
  assign core_advance = (state_reg == cwi_pkg::CWI_RUN) && !stall && !nmi_take && !irq_take;

  // Sequencer next state: reset delay, stacking and two vector reads.
  always_comb begin
    state_next = state_reg;
    src_next = src_reg;
    delay_next = delay_reg;
    push_idx_next = push_idx_reg;
    mask_next = mask_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    write_next = 1'b0;
    stack_next = stack_reg;
    pcl_next = pcl_reg;
    pch_next = pch_reg;
    vec_load_next = 1'b0;
    ba_next = !ready_in && rw_read;
    if (mask_clear) begin
      mask_next = 1'b0;
    end
    if (mask_set) begin
      mask_next = 1'b1;
    end
    case (state_reg)
      cwi_pkg::CWI_RESET: begin
        delay_next = 4'h0;
        src_next = cwi_pkg::CWI_SRC_RESET;
        mask_next = 1'b1;
        if (cpu_reset_n) begin
          state_next = cwi_pkg::CWI_DELAY;
        end
      end
      cwi_pkg::CWI_DELAY: begin
        if (delay_reg + 4'h1 >= `CWI_RESET_DELAY) begin
          state_next = cwi_pkg::CWI_VEC_LO;
          addr_next = `CWI_RESET_VEC_LO;
        end else begin
          delay_next = delay_reg + 4'h1;
        end
      end
      cwi_pkg::CWI_RUN: begin
        if (nmi_take || irq_take) begin
          src_next = nmi_take ? cwi_pkg::CWI_SRC_NMI : cwi_pkg::CWI_SRC_IRQ;
          state_next = cwi_pkg::CWI_PUSH;
          push_idx_next = 2'h0;
          pch_next = core_pc_high_byte;
          pcl_next = core_pc_low_byte;
          addr_next = {8'h01, stack_reg};
          wdata_next = core_pc_high_byte;
          write_next = 1'b1;
        end
      end
      cwi_pkg::CWI_PUSH: begin
        // Push high byte, low byte, then status, walking the stack downward.
        stack_next = stack_reg - 8'h01;
        if (push_idx_reg == 2'h2) begin
          state_next = cwi_pkg::CWI_VEC_LO;
          addr_next = (src_reg == cwi_pkg::CWI_SRC_NMI) ? `CWI_NMI_VEC_LO : `CWI_IRQ_VEC_LO;
        end else begin
          push_idx_next = push_idx_reg + 2'h1;
          addr_next = {8'h01, stack_reg - 8'h01};
          wdata_next = (push_idx_reg == 2'h0) ? pcl_reg : core_status;
          write_next = 1'b1;
        end
      end
      cwi_pkg::CWI_VEC_LO: begin
        if (!stall) begin
          pcl_next = mem_rdata;
          addr_next = addr_reg + 16'h0001;
          state_next = cwi_pkg::CWI_VEC_HI;
        end
      end
      cwi_pkg::CWI_VEC_HI: begin
        mask_next = 1'b1;
        if (!stall) begin
          pch_next = mem_rdata;
          vec_load_next = 1'b1;
          state_next = cwi_pkg::CWI_RUN;
        end
      end
      default: begin
        state_next = cwi_pkg::CWI_RESET;
      end
    endcase
    if (!cpu_reset_n) begin
      state_next = cwi_pkg::CWI_RESET;
      write_next = 1'b0;
    end
  end

  // State registers; the clock enable freezes everything.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= cwi_pkg::CWI_RESET;
      src_reg <= cwi_pkg::CWI_SRC_RESET;
      delay_reg <= 4'h0;
      push_idx_reg <= 2'h0;
      mask_reg <= 1'b1;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      write_reg <= 1'b0;
      stack_reg <= 8'hFF;
      pcl_reg <= 8'h00;
      pch_reg <= 8'h00;
      vec_load_reg <= 1'b0;
      ba_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      src_reg <= src_next;
      delay_reg <= delay_next;
      push_idx_reg <= push_idx_next;
      mask_reg <= mask_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      write_reg <= write_next;
      stack_reg <= stack_next;
      pcl_reg <= pcl_next;
      pch_reg <= pch_next;
      vec_load_reg <= vec_load_next;
      ba_reg <= ba_next;
    end
  end

  // A core write shows on the direction line only while running, so reset masks it at once.
  assign rw_read = !write_reg && !(core_write && cpu_reset_n && state_reg == cwi_pkg::CWI_RUN);
  assign bus_avail = ba_reg;
  assign addr = addr_reg;
  assign wdata = wdata_reg;
  assign mask_flag = mask_reg;
  assign pc_low_byte = pcl_reg;
  assign pc_high_byte = pch_reg;
  assign vector_load = vec_load_reg;
  assign int_busy = (state_reg != cwi_pkg::CWI_RUN);

  // Writes never appear while reset is held.
  no_write_reset_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !cpu_reset_n |=> rw_read) else $error("write during reset");
  // Write cycles are never stretched: the push walk always moves on.
  write_no_stall_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && state_reg == cwi_pkg::CWI_PUSH && cpu_reset_n && push_idx_reg == 2'h0 |=> push_idx_reg == 2'h1 || !ce)
    else $error("push stalled");
  // A stalled read holds the vector fetch in place.
  ready_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && state_reg == cwi_pkg::CWI_VEC_LO && !ready_in && cpu_reset_n |=> state_reg == cwi_pkg::CWI_VEC_LO)
    else $error("vector read advanced during stall");
  // Ready high at the closing edge completes the vector read at that very edge.
  ready_delay_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && state_reg == cwi_pkg::CWI_VEC_LO && ready_in && cpu_reset_n |=> state_reg == cwi_pkg::CWI_VEC_HI)
    else $error("ready sample lost");
  // Reset vector fetched six cycles after release.
  reset_vec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && state_reg == cwi_pkg::CWI_RESET && cpu_reset_n ##1 (ce && cpu_reset_n)[*6]
    |=> addr == `CWI_RESET_VEC_LO) else $error("reset vector timing");
  // The mask flag stands from the cycle after the final vector read starts.
  mask_at_vec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && state_reg == cwi_pkg::CWI_VEC_HI && !mask_clear |=> mask_flag) else $error("mask not set");
  // A masked level request never starts the stacking walk.
  irq_masked_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && mask_flag && state_reg == cwi_pkg::CWI_RUN && cpu_reset_n
    |=> !(state_reg == cwi_pkg::CWI_PUSH && src_reg == cwi_pkg::CWI_SRC_IRQ)) else $error("masked level taken");
  // The edge request is taken regardless of the mask and uses the lower vector.
  nmi_vec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && nmi_take && cpu_reset_n ##1 (ce && cpu_reset_n)[*3] |=> addr == `CWI_NMI_VEC_LO)
    else $error("edge vector wrong");
  // Bus available follows a stalled read one cycle later.
  ba_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !ready_in && rw_read |=> bus_avail) else $error("bus available late");
endmodule // cwi_ctrl
`default_nettype wire

// ==== rtl/cwi_edge_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
// Latches a falling edge of an active-low request once it has stayed low long enough.
module cwi_edge_detect #(
  parameter logic [1:0] MIN_LOW = 2'h2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_n,
  input wire logic clear,
  output logic pending
);
  logic armed_reg;
  logic armed_next;
  logic [1:0] low_cnt_reg;
  logic [1:0] low_cnt_next;
  logic pending_reg;
  logic pending_next;

  // A request is armed by a high level, so a line held low raises only one request.
  always_comb begin
    armed_next = armed_reg;
    low_cnt_next = low_cnt_reg;
    pending_next = pending_reg;
    if (clear) begin
      pending_next = 1'b0;
    end
    if (req_n) begin
      armed_next = 1'b1;
      low_cnt_next = 2'h0;
    end else if (armed_reg) begin
      if (low_cnt_reg + 2'h1 >= MIN_LOW) begin
        pending_next = 1'b1; // Set wins over a clear in the same cycle.
        armed_next = 1'b0;
      end else begin
        low_cnt_next = low_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      armed_reg <= 1'b0;
      low_cnt_reg <= 2'h0;
      pending_reg <= 1'b0;
    end else if (ce) begin
      armed_reg <= armed_next;
      low_cnt_reg <= low_cnt_next;
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;
endmodule // cwi_edge_detect
`default_nettype wire

// ==== rtl/cwi_pkg.sv ====
package cwi_pkg;
  // Sequencer states, Gray coded along the interrupt path and the start-up path except the delay to low vector step.
  typedef enum logic [2:0] {
    CWI_RESET = 3'b000,
    CWI_DELAY = 3'b001,
    CWI_RUN = 3'b011,
    CWI_PUSH = 3'b010,
    CWI_VEC_LO = 3'b110,
    CWI_VEC_HI = 3'b111
  } cwi_state_type;
  typedef enum logic [1:0] {
    CWI_SRC_RESET = 2'h0,
    CWI_SRC_NMI = 2'h1,
    CWI_SRC_IRQ = 2'h2
  } cwi_src_type;
endpackage
